// ===== rtl/pmc_pkg.sv
// shared constants and types for the position measurement channels
package pmc_pkg;
   localparam int NCH = 8;
   localparam int AW = 9;
   // register byte offsets
   localparam logic [8:0] OFF_POS_DATA = 9'h000;
   localparam logic [8:0] OFF_VEL_OUT = 9'h020;
   localparam logic [8:0] OFF_POS_SCALE = 9'h040;
   localparam logic [8:0] OFF_ACTIVE = 9'h060;
   localparam logic [8:0] OFF_VERIFY = 9'h064;
   localparam logic [8:0] OFF_TEST_EN = 9'h068;
   localparam logic [8:0] OFF_SIG_STAT = 9'h06c;
   localparam logic [8:0] OFF_EXC_STAT = 9'h070;
   localparam logic [8:0] OFF_TEST_STAT = 9'h074;
   localparam logic [8:0] OFF_LATCH = 9'h078;
   localparam logic [8:0] OFF_TEST_POS = 9'h07c;
   localparam logic [8:0] OFF_WIRE_MODE = 9'h080;
   localparam logic [8:0] OFF_RESOLUTION = 9'h084;
   localparam logic [8:0] OFF_VEL_SCALE = 9'h0a4;
   localparam logic [8:0] OFF_MAGNITUDE = 9'h0c4;
   localparam logic [8:0] OFF_INT_EN = 9'h1bc;
   localparam logic [8:0] OFF_INT_STAT = 9'h1c0;
   // field positions
   localparam int BIT_LATCH = 1;
   localparam int BIT_LOOPBACK = 0;
   localparam int BIT_BACKGROUND = 2;
   localparam int BIT_OFFLINE = 3;
   localparam int BIT_COMMUTATION = 15;
   localparam int INT_SIG_LOSS = 0;
   localparam int INT_EXC_LOSS = 1;
   localparam int INT_TEST_ERR = 3;
   // reset values, velocity scale limit and verify mark
   localparam logic [15:0] RST_POS_SCALE = 16'hffff;
   localparam logic [15:0] RST_VEL_SCALE = 16'h0fff;
   localparam logic [15:0] VEL_SCALE_MAX = 16'hfff0;
   localparam logic [15:0] RST_RESOLUTION = 16'h0004;
   localparam logic [15:0] VERIFY_MARK = 16'h0055;
   // self-test stimulus and tolerance (0.1 percent of 32768), velocity shift
   localparam logic [15:0] STIM_DEN = 16'h8000;
   localparam logic [15:0] STIM_STEP = 16'h1111;
   localparam logic [15:0] TEST_TOL = 16'h0021;
   localparam int VEL_SHIFT = 8;
   // timing
   localparam longint CLK_HZ = 50_000_000;
   localparam longint LOSS_TIME_MS = 2000;
   localparam longint OFFLINE_TIME_MS = 10000;
   localparam int LOSS_CYCLES = int'(CLK_HZ / 1000 * LOSS_TIME_MS);
   localparam int OFFLINE_CYCLES = int'(CLK_HZ / 1000 * OFFLINE_TIME_MS);

   // what the analog front end hands over per channel
   typedef struct packed {
      logic signed [15:0] diff;
      logic [15:0] sum;
      logic [15:0] exc;
      logic sig_present;
      logic exc_present;
   } pmc_sense_t;

   // encoder output per channel
   typedef struct packed {
      logic commutation;
      logic [2:0] res_code;
      logic [15:0] count;
   } pmc_enc_t;
endpackage : pmc_pkg

// ===== rtl/pmc_divider.sv
// sequential restoring divider with saturated signed-positive quotient
`timescale 1ns/1ns
module pmc_divider #(
   parameter int NW = 48,
   parameter int DW = 32,
   parameter int QW = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   output logic done,
   output logic [QW-1:0] quot
);
   import pmc_pkg::*;
   logic [DW:0] rem_reg;
   logic [NW-1:0] num_reg;
   logic [NW-1:0] q_reg;
   logic [DW-1:0] den_reg;
   logic [7:0] cnt_reg;
   logic [DW:0] trial;
   logic fits;

   assign trial = {rem_reg[DW-1:0], num_reg[NW-1]};
   assign fits = trial >= {1'b0, den_reg};

   // one quotient bit per cycle; trades speed for a small footprint
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rem_reg <= '0;
         num_reg <= '0;
         q_reg <= '0;
         den_reg <= '0;
         cnt_reg <= 8'h00;
         done <= 1'b0;
         quot <= '0;
      end else begin
         done <= 1'b0;
         if (start) begin
            rem_reg <= '0;
            num_reg <= num;
            q_reg <= '0;
            den_reg <= den;
            cnt_reg <= 8'(NW);
         end else if (cnt_reg != 8'h00) begin
            rem_reg <= fits ? (trial - {1'b0, den_reg}) : trial;
            num_reg <= {num_reg[NW-2:0], 1'b0};
            q_reg <= {q_reg[NW-2:0], fits};
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
               done <= 1'b1;
            end
         end
         // clamp at the largest positive word, also for a zero divisor
         if (cnt_reg == 8'h01) begin
            if (den_reg == '0 || (|{q_reg[NW-2:QW-2], fits} & |q_reg[NW-2:QW-2])) begin
               quot <= {1'b0, {(QW-1){1'b1}}};
            end else begin
               quot <= {q_reg[QW-2:0], fits};
            end
         end
      end
   end
endmodule : pmc_divider

// ===== rtl/pmc_loss_timer.sv
// flags a missing input once it has stayed absent for the loss time
`timescale 1ns/1ns
module pmc_loss_timer #(
   parameter int LOSS_CYCLES = pmc_pkg::LOSS_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic present,
   output logic lost
);
   import pmc_pkg::*;
   logic [31:0] cnt_reg;

   // a short dropout restarts the count, so only a steady loss is flagged
   always_ff @(posedge sys_clk) begin
      if (rst || !enable || present) begin
         cnt_reg <= 32'h0000_0000;
         lost <= 1'b0;
      end else if (cnt_reg >= 32'(LOSS_CYCLES - 1)) begin
         lost <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
      end
   end
endmodule : pmc_loss_timer

// ===== rtl/pmc_channels.sv
// register file, shared converter and self-test for eight position channels
// What this block does
// - active-channel bits enable monitoring; unused channels left active report faults
// - wire-mode bit one picks two-wire input, zero picks three/four-wire
// - three/four-wire position is difference over sum, two's complement word
// - two-wire position is difference over excitation, same word range
// - scale resets to ffff; smaller values reach full scale earlier
// - sum magnitude reads in hundredths of a volt, valid only three/four-wire
// - velocity scale resets to 0fff, highest permitted setting fff0
// - velocity reads two's complement, 7fff clockwise to 8000 counter-clockwise
// - velocity scale changes the velocity word only, not tracking
// - latch write with D1 set freezes every channel at once
// - reading a channel releases it; writing zero releases all
// - test-enable D2 runs background self-test alongside conversion
// - background test writes 55 into verify register; host may clear it
// - excitation and signal loss raise enabled interrupts and status
// - D3 isolates channels onto stimulus, about ten seconds, then clears
// - off-line test failure raises enabled interrupt
// - loss monitoring stops during off-line or loop-back test
// - D0 converts host test position instead of inputs; host waits 50 ms
// - test status one means good, failures latch until read
// - excitation status one means present, loss after two seconds latches
// - signal status one means present, loss after two seconds latches
// - resolution D15 zero selects encoder, code in D2..D0, default 12 bit
// - interrupt status captures enabled failures, clears on read
// - sources are signal loss, excitation loss, test error, each enabled
`timescale 1ns/1ns
module pmc_channels #(
   parameter int NCH = pmc_pkg::NCH,
   parameter int LOSS_CYCLES = pmc_pkg::LOSS_CYCLES,
   parameter int OFFLINE_CYCLES = pmc_pkg::OFFLINE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [pmc_pkg::AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire pmc_pkg::pmc_sense_t sense [NCH],
   output pmc_pkg::pmc_enc_t enc [NCH],
   output logic test_isolate,
   output logic irq
);
   import pmc_pkg::*;

   typedef enum {ST_LOAD, ST_WAIT, ST_STORE} pmc_state_t;

   // hit test for a bank of one word per channel
   function automatic logic bank_hit(input logic [AW-1:0] a, input logic [AW-1:0] base);
      logic [AW-1:0] d;
      d = a - base;
      return (a >= base) && (d < AW'(4 * NCH)) && (a[1:0] == 2'b00);
   endfunction : bank_hit

   function automatic logic [2:0] bank_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
      logic [AW-1:0] d;
      d = a - base;
      return d[4:2];
   endfunction : bank_idx

   logic [15:0] scale_reg [NCH];
   logic [15:0] vscale_reg [NCH];
   logic [15:0] res_reg [NCH];
   logic [15:0] pos_live [NCH];
   logic [15:0] pos_out [NCH];
   logic [15:0] vel_out [NCH];
   logic [15:0] mag_out [NCH];
   logic [NCH-1:0] active_reg, wire2_reg, latched_reg;
   logic [NCH-1:0] sig_fail_reg, exc_fail_reg, test_fail_reg, off_fail_reg;
   logic [NCH-1:0] sig_lost, exc_lost;
   logic [15:0] test_en_reg, verify_reg, test_pos_reg, stim_reg;
   logic [15:0] int_en_reg, int_stat_reg;
   logic [31:0] off_cnt_reg;
   logic [3:0] slot_reg;
   pmc_state_t state_reg;
   logic div_start, div_done;
   logic [47:0] div_num;
   logic [31:0] div_den;
   logic [15:0] div_quot;
   logic neg_reg, conv_stim_reg;
   logic suspend, offline_on, stim_slot, bg_pass, bg_fail_evt, off_end;
   logic [2:0] ch;
   logic [15:0] pos_new, sel_scale, sel_den, abs_diff;
   logic signed [15:0] sel_diff;
   logic signed [16:0] dpos;
   logic signed [33:0] vel_prod;
   logic signed [33:0] vel_shift;
   logic [15:0] vel_new, pos_err;
   logic wr_test_en, rd_sig, rd_exc, rd_test, rd_int;
   logic [NCH-1:0] sig_evt, exc_evt;

   assign ch = slot_reg[2:0];
   assign offline_on = test_en_reg[BIT_OFFLINE];
   assign suspend = offline_on || test_en_reg[BIT_LOOPBACK];
   assign test_isolate = suspend;
   assign stim_slot = (slot_reg == 4'(NCH)) || offline_on;
   assign wr_test_en = reg_wr && reg_addr == OFF_TEST_EN;
   assign rd_sig = reg_rd && reg_addr == OFF_SIG_STAT;
   assign rd_exc = reg_rd && reg_addr == OFF_EXC_STAT;
   assign rd_test = reg_rd && reg_addr == OFF_TEST_STAT;
   assign rd_int = reg_rd && reg_addr == OFF_INT_STAT;

   // loss monitors, one pair per channel, held off on unused channels and in isolation
   for (genvar i = 0; i < NCH; i++) begin : g_mon
      pmc_loss_timer #(.LOSS_CYCLES(LOSS_CYCLES)) u_sig (
         .sys_clk(sys_clk),
         .rst(rst),
         .enable(active_reg[i] && !suspend),
         .present(sense[i].sig_present),
         .lost(sig_lost[i])
      );
      pmc_loss_timer #(.LOSS_CYCLES(LOSS_CYCLES)) u_exc (
         .sys_clk(sys_clk),
         .rst(rst),
         .enable(active_reg[i] && !suspend),
         .present(sense[i].exc_present),
         .lost(exc_lost[i])
      );
      // encoder word keeps only the selected number of top bits
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            enc[i] <= '{RST_RESOLUTION[BIT_COMMUTATION], RST_RESOLUTION[2:0], 16'h0000};
         end else begin
            enc[i].commutation <= res_reg[i][BIT_COMMUTATION];
            enc[i].res_code <= res_reg[i][2:0];
            enc[i].count <= pos_live[i] & (16'hffff << res_reg[i][2:0]);
         end
      end
   end

   // converter input selection: stimulus slot, two-wire or three/four-wire
   always_comb begin
      if (stim_slot) begin
         sel_diff = stim_reg;
         sel_den = STIM_DEN;
         sel_scale = RST_POS_SCALE;
      end else if (wire2_reg[ch]) begin
         sel_diff = sense[ch].diff;
         sel_den = sense[ch].exc;
         sel_scale = scale_reg[ch];
      end else begin
         sel_diff = sense[ch].diff;
         sel_den = sense[ch].sum;
         sel_scale = scale_reg[ch];
      end
      abs_diff = sel_diff[15] ? 16'(-sel_diff) : sel_diff;
   end

   // ratio times 2^15, times 2^16 over scale: a smaller scale raises the gain
   assign div_num = {1'b0, abs_diff, 31'h0000_0000};
   assign div_den = sel_den * sel_scale;
   assign div_start = state_reg == ST_LOAD;

   pmc_divider #(.NW(48), .DW(32), .QW(16)) u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .done(div_done),
      .quot(div_quot)
   );

   // signed result; the loop-back test bypasses the inputs for position and velocity
   always_comb begin
      if (test_en_reg[BIT_LOOPBACK] && !stim_slot) begin
         pos_new = test_pos_reg;
      end else begin
         pos_new = neg_reg ? 16'(-div_quot) : div_quot;
      end
      pos_err = (pos_new > stim_reg) ? 16'(pos_new - stim_reg) : 16'(stim_reg - pos_new);
      dpos = 17'(signed'(pos_new)) - 17'(signed'(pos_live[ch]));
      vel_prod = 34'(dpos) * 34'(signed'({1'b0, vscale_reg[ch]}));
      vel_shift = vel_prod >>> VEL_SHIFT;
      if (vel_shift > 34'sd32767) begin
         vel_new = 16'h7fff;
      end else if (vel_shift < -34'sd32768) begin
         vel_new = 16'h8000;
      end else begin
         vel_new = vel_shift[15:0];
      end
   end

   assign bg_pass = pos_err <= TEST_TOL;
   assign bg_fail_evt = state_reg == ST_STORE && slot_reg == 4'(NCH) && !offline_on
      && test_en_reg[BIT_BACKGROUND] && !bg_pass;
   assign off_end = offline_on && off_cnt_reg >= 32'(OFFLINE_CYCLES - 1);

   // conversion sequencer: channels in turn, then one stimulus slot
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= ST_LOAD;
         slot_reg <= 4'h0;
         neg_reg <= 1'b0;
         conv_stim_reg <= 1'b0;
         stim_reg <= 16'h0000;
      end else begin
         case (state_reg)
            ST_LOAD: begin
               neg_reg <= sel_diff[15];
               conv_stim_reg <= stim_slot; // a conversion begun on live inputs is never judged as a test
               state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (div_done) begin
                  state_reg <= ST_STORE;
               end
            end
            ST_STORE: begin
               state_reg <= ST_LOAD;
               if (slot_reg == 4'(NCH)) begin
                  slot_reg <= 4'h0;
                  stim_reg <= stim_reg + STIM_STEP;
               end else begin
                  slot_reg <= slot_reg + 4'h1;
               end
            end
            default: state_reg <= ST_LOAD;
         endcase
      end
   end

   // channel results; the frozen copy only moves while unlatched
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            pos_live[i] <= 16'h0000;
            pos_out[i] <= 16'h0000;
            vel_out[i] <= 16'h0000;
            mag_out[i] <= 16'h0000;
         end
      end else if (state_reg == ST_STORE && slot_reg < 4'(NCH)) begin
         pos_live[ch] <= pos_new;
         if (!latched_reg[ch]) begin
            pos_out[ch] <= pos_new;
            vel_out[ch] <= vel_new;
            mag_out[ch] <= wire2_reg[ch] ? 16'h0000 : sense[ch].sum;
         end
      end
   end

   // latch: all at once on D1, per channel release on a data read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         latched_reg <= '0;
      end else if (reg_wr && reg_addr == OFF_LATCH) begin
         latched_reg <= reg_wdata[BIT_LATCH] ? '1 : '0;
      end else if (reg_rd && bank_hit(reg_addr, OFF_POS_DATA)) begin
         latched_reg[bank_idx(reg_addr, OFF_POS_DATA)] <= 1'b0;
      end
   end

   // host-written configuration
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         active_reg <= '0;
         wire2_reg <= '0;
         test_pos_reg <= 16'h0000;
         int_en_reg <= 16'h0000;
         for (int i = 0; i < NCH; i++) begin
            scale_reg[i] <= RST_POS_SCALE;
            vscale_reg[i] <= RST_VEL_SCALE;
            res_reg[i] <= RST_RESOLUTION;
         end
      end else if (reg_wr) begin
         if (reg_addr == OFF_ACTIVE) active_reg <= reg_wdata[NCH-1:0];
         if (reg_addr == OFF_WIRE_MODE) wire2_reg <= reg_wdata[NCH-1:0];
         if (reg_addr == OFF_TEST_POS) test_pos_reg <= reg_wdata;
         if (reg_addr == OFF_INT_EN) int_en_reg <= reg_wdata;
         if (bank_hit(reg_addr, OFF_POS_SCALE)) scale_reg[bank_idx(reg_addr, OFF_POS_SCALE)] <= reg_wdata;
         if (bank_hit(reg_addr, OFF_VEL_SCALE)) begin
            // settings past the top limit are clamped to it
            vscale_reg[bank_idx(reg_addr, OFF_VEL_SCALE)] <=
               (reg_wdata > VEL_SCALE_MAX) ? VEL_SCALE_MAX : reg_wdata;
         end
         if (bank_hit(reg_addr, OFF_RESOLUTION)) begin
            res_reg[bank_idx(reg_addr, OFF_RESOLUTION)] <=
               {reg_wdata[BIT_COMMUTATION], 12'h000, reg_wdata[2:0]};
         end
      end
   end

   // test enable: the off-line test ends itself after its run time
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         test_en_reg <= 16'h0000;
         off_cnt_reg <= 32'h0000_0000;
      end else begin
         if (wr_test_en) begin
            test_en_reg <= reg_wdata & 16'h000d; // host 0 on D3 aborts
            off_cnt_reg <= 32'h0000_0000;
         end else if (off_end) begin
            test_en_reg[BIT_OFFLINE] <= 1'b0; // results ready
         end else if (offline_on) begin
            off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // verify word: device keeps rewriting 55 while background test runs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         verify_reg <= 16'h0000;
      end else if (test_en_reg[BIT_BACKGROUND] && state_reg == ST_STORE && slot_reg == 4'(NCH)) begin
         verify_reg <= VERIFY_MARK; // device write wins over host
      end else if (reg_wr && reg_addr == OFF_VERIFY) begin
         verify_reg <= reg_wdata;
      end
   end

   // off-line per channel verdict, folded into test status at the end
   always_ff @(posedge sys_clk) begin
      if (rst || (wr_test_en && reg_wdata[BIT_OFFLINE])) begin
         off_fail_reg <= '0;
      end else if (offline_on && conv_stim_reg && state_reg == ST_STORE && slot_reg < 4'(NCH) && !bg_pass) begin
         off_fail_reg[ch] <= 1'b1;
      end
   end

   // sticky failures: new events win over the clearing read
   assign sig_evt = sig_lost & ~sig_fail_reg;
   assign exc_evt = exc_lost & ~exc_fail_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sig_fail_reg <= '0;
         exc_fail_reg <= '0;
         test_fail_reg <= '0;
      end else begin
         sig_fail_reg <= (rd_sig ? '0 : sig_fail_reg) | sig_lost;
         exc_fail_reg <= (rd_exc ? '0 : exc_fail_reg) | exc_lost;
         test_fail_reg <= (rd_test ? '0 : test_fail_reg)
            | (bg_fail_evt ? active_reg : '0)
            | (off_end ? (off_fail_reg & active_reg) : '0);
      end
   end

   // interrupt status: enabled sources latch, cleared by a read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         int_stat_reg <= 16'h0000;
      end else begin
         int_stat_reg <= (rd_int ? 16'h0000 : int_stat_reg) | (int_en_reg & {
            12'h000,
            bg_fail_evt || (off_end && |(off_fail_reg & active_reg)),
            1'b0,
            |exc_evt,
            |sig_evt});
      end
   end
   assign irq = |(int_stat_reg & int_en_reg);

   // read data, registered one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= 16'h0000;
         if (bank_hit(reg_addr, OFF_POS_DATA)) reg_rdata <= pos_out[bank_idx(reg_addr, OFF_POS_DATA)];
         if (bank_hit(reg_addr, OFF_VEL_OUT)) reg_rdata <= vel_out[bank_idx(reg_addr, OFF_VEL_OUT)];
         if (bank_hit(reg_addr, OFF_POS_SCALE)) reg_rdata <= scale_reg[bank_idx(reg_addr, OFF_POS_SCALE)];
         if (bank_hit(reg_addr, OFF_VEL_SCALE)) reg_rdata <= vscale_reg[bank_idx(reg_addr, OFF_VEL_SCALE)];
         if (bank_hit(reg_addr, OFF_RESOLUTION)) reg_rdata <= res_reg[bank_idx(reg_addr, OFF_RESOLUTION)];
         if (bank_hit(reg_addr, OFF_MAGNITUDE)) reg_rdata <= mag_out[bank_idx(reg_addr, OFF_MAGNITUDE)];
         case (reg_addr)
            OFF_ACTIVE: reg_rdata <= 16'(active_reg);
            OFF_WIRE_MODE: reg_rdata <= 16'(wire2_reg);
            OFF_VERIFY: reg_rdata <= verify_reg;
            OFF_TEST_EN: reg_rdata <= test_en_reg;
            OFF_TEST_POS: reg_rdata <= test_pos_reg;
            OFF_SIG_STAT: reg_rdata <= 16'(active_reg & ~sig_fail_reg & ~sig_lost);
            OFF_EXC_STAT: reg_rdata <= 16'(active_reg & ~exc_fail_reg & ~exc_lost);
            OFF_TEST_STAT: reg_rdata <= 16'(active_reg & ~test_fail_reg);
            OFF_INT_EN: reg_rdata <= int_en_reg;
            OFF_INT_STAT: reg_rdata <= int_stat_reg;
            default: ;
         endcase
      end
   end
endmodule : pmc_channels

// ===== verification/pmc_sensor_model.sv
// behavioural transducer set feeding all eight channels
`timescale 1ns/1ns
module pmc_sensor_model (
   input wire logic signed [15:0] diff_v,
   input wire logic [15:0] sum_v,
   input wire logic [15:0] exc_v,
   input wire logic [7:0] gone,
   output pmc_pkg::pmc_sense_t sense [8]
);
   import pmc_pkg::*;
   // a lost sensor drops presence and shows an inverted difference reading; sum and excitation pass unchanged
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         sense[i] = '{diff_v ^ {16{gone[i]}}, sum_v, exc_v, ~gone[i], ~gone[i]};
      end
   end
endmodule : pmc_sensor_model

// ===== verification/pmc_channels_properties.sv
// timing relations on the register port, encoder outputs and flags
`timescale 1ns/1ns
module pmc_channels_properties #(
   parameter int NCH = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [pmc_pkg::AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire pmc_pkg::pmc_enc_t enc [NCH],
   input wire logic test_isolate,
   input wire logic irq
);
   import pmc_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic ten_wr;
   logic res_wr;
   // decoded writes shared by several checks
   assign ten_wr = reg_wr && reg_addr == OFF_TEST_EN;
   assign res_wr = reg_wr && reg_addr == OFF_RESOLUTION;
   isolate_on_a: assert property (ten_wr && (reg_wdata[0] || reg_wdata[3]) |=> test_isolate)
      else $error("isolation not raised");
   isolate_off_a: assert property (ten_wr && !reg_wdata[0] && !reg_wdata[3] |=> !test_isolate)
      else $error("isolation not dropped");
   irq_off_a: assert property (reg_wr && reg_addr == OFF_INT_EN && reg_wdata == 16'h0 |=> !irq)
      else $error("irq high with no source enabled");
   vscale_cap_a: assert property (reg_rd && reg_addr >= OFF_VEL_SCALE && reg_addr < OFF_MAGNITUDE |=>
      reg_rdata <= VEL_SCALE_MAX)
      else $error("velocity scale above limit");
   res_code_a: assert property (res_wr |-> ##2 enc[0].res_code == $past(reg_wdata[2:0], 2))
      else $error("encoder code not applied");
   commut_sel_a: assert property (res_wr |-> ##2 enc[0].commutation == $past(reg_wdata[15], 2))
      else $error("encoder mode not applied");
   count_mask_a: assert property ((enc[0].count & ~(16'hffff << enc[0].res_code)) == 16'h0)
      else $error("count finer than resolution");
   reset_quiet_a: assert property ($fell(rst) |-> !irq && !test_isolate && enc[0].res_code == 3'h4)
      else $error("outputs wrong after reset");
   c_offline: cover property (ten_wr && reg_wdata[3]);
   c_irq: cover property ($rose(irq));
   c_done: cover property ($fell(test_isolate) && !$past(reg_wr));
endmodule : pmc_channels_properties
bind pmc_channels pmc_channels_properties #(.NCH(NCH)) chk_u (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .enc, .test_isolate, .irq);

// ===== verification/position_measurement_channels_bench.sv
// self-checking bench for the position measurement channels
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end end
module position_measurement_channels_bench;
   import pmc_pkg::*;
   logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq, test_isolate, rd_pend = 0;
   logic [8:0] reg_addr = '0, adr_v;
   logic [15:0] reg_wdata = '0, reg_rdata, exp_v, sum_v = 16'h07d0, exc_v = 16'h07d0;
   logic signed [15:0] diff_v = 16'sh03e8;
   logic [7:0] gone = '0;
   pmc_sense_t sense [NCH];
   pmc_enc_t enc [NCH];
   logic [15:0] exp_q [$];
   logic [8:0] adr_q [$];
   int err_total = 0, num_checks = 0, cyc = 0, seed = 4541;
   always #10 sys_clk = ~sys_clk;
   // short loss and off-line counts keep the run brief
   pmc_channels #(.LOSS_CYCLES(20), .OFFLINE_CYCLES(2000)) dut_u (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .sense, .enc, .test_isolate, .irq);
   pmc_sensor_model snsr_u (.diff_v, .sum_v, .exc_v, .gone, .sense);
   task automatic wrap_up;
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      @(negedge sys_clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(negedge sys_clk);
      reg_rd = 1'b0;
   endtask : rd
   // read answers land one edge after the strobe; hang guard
   always @(posedge sys_clk) begin
      rd_pend <= reg_rd;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         wrap_up();
      end
   end
   // scoreboard: oldest note against each answer
   always @(negedge sys_clk) begin
      if (rd_pend) begin
         exp_v = exp_q.pop_front();
         adr_v = adr_q.pop_front();
         `CHK($sformatf("rd %h", adr_v), exp_v, reg_rdata)
      end
   end
   initial begin
      repeat (4) @(negedge sys_clk);
      rst = 0;
      rd(OFF_POS_SCALE, 16'hffff);
      rd(OFF_VEL_SCALE, 16'h0fff);
      rd(OFF_RESOLUTION, 16'h0004);
      rd(9'h1fc, 16'h0);
      wr(OFF_VEL_SCALE, 16'hffff);
      rd(OFF_VEL_SCALE, 16'hfff0);
      for (int i = 0; i < 8; i++) begin
         wr(OFF_RESOLUTION, {i[0], 12'h0, i[2:0]});
         rd(OFF_RESOLUTION, {i[0], 12'h0, i[2:0]});
      end
      wr(OFF_ACTIVE, 16'h00ff);
      wr(OFF_POS_SCALE + 9'h4, 16'h8000);
      repeat (1000) @(negedge sys_clk);
      rd(OFF_POS_DATA, 16'h4000);
      rd(OFF_POS_DATA + 9'h4, 16'h7fff);
      rd(OFF_VEL_OUT, 16'h0);
      `CHK("enc", {1'b1, 3'h7, 16'h4000}, enc[0])
      wr(OFF_LATCH, 16'h0002);
      diff_v = -16'sh03e8;
      repeat (1000) @(negedge sys_clk);
      rd(OFF_POS_DATA, 16'h4000);
      // a released channel shows new data only after its next conversion
      repeat (500) @(negedge sys_clk);
      rd(OFF_POS_DATA, 16'hc000);
      rd(OFF_POS_DATA + 9'h8, 16'h4000);
      wr(OFF_LATCH, 16'h0);
      repeat (500) @(negedge sys_clk);
      rd(OFF_POS_DATA + 9'h8, 16'hc000);
      // two-wire channel with a half transformation ratio scale
      wr(OFF_WIRE_MODE, 16'h0001);
      wr(OFF_POS_SCALE, 16'h7fff);
      diff_v = 16'sh01f4;
      sum_v = 16'h0100 | $random(seed) & 16'h0fff;
      repeat (1000) @(negedge sys_clk);
      rd(OFF_POS_DATA, 16'h4000);
      rd(OFF_MAGNITUDE, 16'h0);
      rd(OFF_MAGNITUDE + 9'h4, sum_v);
      wr(OFF_TEST_POS, 16'h1234);
      wr(OFF_TEST_EN, 16'h0001);
      repeat (1000) @(negedge sys_clk);
      rd(OFF_POS_DATA + 9'hc, 16'h1234);
      gone = 8'h04;
      repeat (100) @(negedge sys_clk);
      gone = 8'h00;
      wr(OFF_TEST_EN, 16'h0);
      rd(OFF_SIG_STAT, 16'h00ff);
      wr(OFF_TEST_EN, 16'h0008);
      repeat (2200) @(negedge sys_clk);
      rd(OFF_TEST_EN, 16'h0);
      rd(OFF_TEST_STAT, 16'h00ff);
      wr(OFF_INT_EN, 16'h000b);
      gone = 8'h04;
      repeat (100) @(negedge sys_clk);
      gone = 8'h00;
      rd(OFF_SIG_STAT, 16'h00fb);
      rd(OFF_EXC_STAT, 16'h00fb);
      rd(OFF_SIG_STAT, 16'h00ff);
      `CHK("irq", 1'b1, irq)
      rd(OFF_INT_STAT, 16'h0003);
      repeat (2) @(negedge sys_clk);
      `CHK("irq", 1'b0, irq)
      wr(OFF_TEST_EN, 16'h0004);
      wr(OFF_VERIFY, 16'h0);
      repeat (1000) @(negedge sys_clk);
      rd(OFF_VERIFY, 16'h0055);
      wr(OFF_INT_EN, 16'h0);
      repeat (4) @(negedge sys_clk);
      wrap_up();
   end
endmodule : position_measurement_channels_bench
